// File: core/ref_select_pkg.sv
// Constants for reference input selection and digital lock detect
// Overview of operation
// - Mode 0, 1 or 2 fixes the active reference to input 0, 1 or 2.
// - Manual mode keeps the chosen input buffer running despite its enable bit.
// - After holdover in manual mode the same input is relocked.
// - Mode 3 picks the active input from the two select pins.
// - A select pin counts only when typed as input; otherwise it reads low.
// - One invert bit flips both select pins before decoding.
// - Pins 00, 01, 10 pick inputs 0, 1, 2; 11 forces holdover.
// - Pin mode keeps the pin-chosen input buffer running despite its enable bit.
// - Mode 4 advances round-robin 0, 1, 2, 0 on each switch event.
// - Automatic mode skips inputs whose buffer enable is cleared.
// - Entering automatic mode keeps the current input when the first PLL is locked.
// - Each PLL has its own lock detector run on every phase comparison.
// - An in-window comparison increments the lock count while unlocked.
// - Lock asserts when the count reaches the programmed target.
// - Lock drops on the first out-of-window comparison.
// - Each status pin shows first PLL, second PLL, or both combined.
// - Holdover drops first PLL lock and raises a holdover status.
package ref_select_pkg;
   localparam logic [2:0] MODE_MANUAL_0 = 3'h0;
   localparam logic [2:0] MODE_MANUAL_1 = 3'h1;
   localparam logic [2:0] MODE_MANUAL_2 = 3'h2;
   localparam logic [2:0] MODE_PIN      = 3'h3;
   localparam logic [2:0] MODE_AUTO     = 3'h4;
   localparam logic [1:0] STATUS_FIRST  = 2'h0;
   localparam logic [1:0] STATUS_SECOND = 2'h1;
   localparam logic [1:0] STATUS_BOTH   = 2'h2;
   localparam logic [1:0] STATUS_HOLD   = 2'h3;
   localparam logic [1:0] INPUT_0       = 2'h0;
   localparam logic [1:0] INPUT_1       = 2'h1;
   localparam logic [1:0] INPUT_2       = 2'h2;
   localparam logic [1:0] PINS_HOLD     = 2'h3;
   localparam int         COUNT_WIDTH   = 16;
   typedef enum logic [1:0] {
      DET_SEARCH = 2'h0,
      DET_LOCKED = 2'h1
   } det_state_t;
endpackage

// File: core/ref_clock_select_lock_detect.sv
// Reference input selection with lock detect for two PLLs
`timescale 1ns/1ps
module ref_clock_select_lock_detect #(
   parameter int COUNT_WIDTH = ref_select_pkg::COUNT_WIDTH
) (
   input  wire logic                   clk,
   input  wire logic                   srst,
   input  wire logic [2:0]             input_select_mode,
   input  wire logic [2:0]             input_buffer_enable,
   input  wire logic                   select_pin_0,
   input  wire logic                   select_pin_1,
   input  wire logic [1:0]             select_pin_type,
   input  wire logic                   select_pin_invert,
   input  wire logic                   switchEvent,
   input  wire logic                   holdoverExit,
   input  wire logic                   firstCompare,
   input  wire logic                   firstInWindow,
   input  wire logic                   secondCompare,
   input  wire logic                   secondInWindow,
   input  wire logic [COUNT_WIDTH-1:0] first_pll_lock_count_target,
   input  wire logic [COUNT_WIDTH-1:0] second_pll_lock_count_target,
   input  wire logic [1:0]             statusSelectA,
   input  wire logic [1:0]             statusSelectB,
   output logic [1:0]                  activeInput,
   output logic [2:0]                  bufferRun,
   output logic                        holdover,
   output logic                        first_pll_lock,
   output logic                        secondPllLock,
   output logic                        status_pin_a,
   output logic                        status_pin_b
);
   // Elaboration check: count must fit in a sane register
   if (COUNT_WIDTH < 1 || COUNT_WIDTH > 32) begin : gBadWidth
      $error("COUNT_WIDTH out of range");
   end

   ref_select_pkg::det_state_t firstState;
   ref_select_pkg::det_state_t next_firstState;
   ref_select_pkg::det_state_t secondState;
   ref_select_pkg::det_state_t next_secondState;
   logic [COUNT_WIDTH-1:0] firstCount;
   logic [COUNT_WIDTH-1:0] next_firstCount;
   logic [COUNT_WIDTH-1:0] secondCount;
   logic [COUNT_WIDTH-1:0] next_secondCount;
   logic [1:0]             next_activeInput;
   logic                   next_holdover;
   logic [2:0]             prevMode;
   logic                   firstLockRaw;
   logic [1:0]             pinCode;
   logic                   pin0Level;
   logic                   pin1Level;

   // Next enabled input after cur in 0,1,2 order; stays put if none other enabled
   function automatic logic [1:0] nextEnabled(input logic [1:0] cur, input logic [2:0] en);
      logic [1:0] cand;
      logic [1:0] result;
      cand   = cur;
      result = cur;
      for (int i = 0; i < 3; i++) begin
         cand = (cand == ref_select_pkg::INPUT_2) ? ref_select_pkg::INPUT_0 : cand + 2'h1;
         if (en[cand] && result == cur && cand != cur) begin
            result = cand;
         end
      end
      return result;
   endfunction

   // Lock detector step shared by both PLLs
   function automatic logic [COUNT_WIDTH:0] detStep(input logic locked,
                                                    input logic cmp,
                                                    input logic inWin,
                                                    input logic [COUNT_WIDTH-1:0] cnt,
                                                    input logic [COUNT_WIDTH-1:0] tgt);
      logic [COUNT_WIDTH-1:0] c;
      logic                   l;
      c = cnt;
      l = locked;
      if (cmp) begin
         if (!inWin) begin
            c = '0;
            l = 1'b0;
         end else if (!locked) begin
            if (cnt != {COUNT_WIDTH{1'b1}}) begin
               c = cnt + 1'b1;
            end
            if (c >= tgt) begin
               l = 1'b1;
            end
         end
      end
      return {l, c};
   endfunction

   // Pin levels: common inversion, then output-typed pins read low
   always_comb begin
      pin0Level = select_pin_type[0] & (select_pin_0 ^ select_pin_invert);
      pin1Level = select_pin_type[1] & (select_pin_1 ^ select_pin_invert);
      pinCode   = {pin1Level, pin0Level};
   end

   // Active input and holdover selection
   always_comb begin
      next_activeInput = activeInput;
      next_holdover    = holdover;
      case (input_select_mode)
         ref_select_pkg::MODE_MANUAL_0,
         ref_select_pkg::MODE_MANUAL_1,
         ref_select_pkg::MODE_MANUAL_2: begin
            next_activeInput = input_select_mode[1:0];
            if (holdoverExit) begin
               next_holdover = 1'b0;
            end
         end
         ref_select_pkg::MODE_PIN: begin
            if (pinCode == ref_select_pkg::PINS_HOLD) begin
               next_holdover = 1'b1;
            end else begin
               next_activeInput = pinCode;
               next_holdover    = 1'b0;
            end
         end
         ref_select_pkg::MODE_AUTO: begin
            if (holdoverExit) begin
               next_holdover = 1'b0;
            end
            // On entry keep the current input when locked or enabled, else jump to an enabled one
            if (prevMode != ref_select_pkg::MODE_AUTO) begin
               if (!first_pll_lock && !input_buffer_enable[activeInput]) begin
                  next_activeInput = nextEnabled(activeInput, input_buffer_enable);
               end
            end else if (switchEvent || !input_buffer_enable[activeInput]) begin
               next_activeInput = nextEnabled(activeInput, input_buffer_enable);
            end
         end
         default: begin
            next_activeInput = activeInput;
         end
      endcase
   end

   // Buffer run: enable bits, with the manual or pin choice forced on
   always_comb begin
      bufferRun = input_buffer_enable;
      if (input_select_mode <= ref_select_pkg::MODE_PIN) begin
         bufferRun[activeInput] = 1'b1;
      end
   end

   // Lock detector next state for both PLLs
   always_comb begin
      logic [COUNT_WIDTH:0] r1;
      logic [COUNT_WIDTH:0] r2;
      r1 = detStep(firstState == ref_select_pkg::DET_LOCKED, firstCompare, firstInWindow,
                   firstCount, first_pll_lock_count_target);
      r2 = detStep(secondState == ref_select_pkg::DET_LOCKED, secondCompare, secondInWindow,
                   secondCount, second_pll_lock_count_target);
      next_firstCount  = r1[COUNT_WIDTH-1:0];
      next_secondCount = r2[COUNT_WIDTH-1:0];
      next_firstState  = r1[COUNT_WIDTH] ? ref_select_pkg::DET_LOCKED : ref_select_pkg::DET_SEARCH;
      next_secondState = r2[COUNT_WIDTH] ? ref_select_pkg::DET_LOCKED : ref_select_pkg::DET_SEARCH;
   end

   // Registers for selection and detectors
   always_ff @(posedge clk) begin
      if (srst) begin
         activeInput <= ref_select_pkg::INPUT_0;
         holdover    <= 1'b0;
         prevMode    <= ref_select_pkg::MODE_MANUAL_0;
         firstState  <= ref_select_pkg::DET_SEARCH;
         secondState <= ref_select_pkg::DET_SEARCH;
         firstCount  <= '0;
         secondCount <= '0;
      end else begin
         activeInput <= next_activeInput;
         holdover    <= next_holdover;
         prevMode    <= input_select_mode;
         firstState  <= next_firstState;
         secondState <= next_secondState;
         firstCount  <= next_firstCount;
         secondCount <= next_secondCount;
      end
   end

   // Holdover masks first lock; detector keeps counting so exit can be seen
   assign firstLockRaw   = (firstState == ref_select_pkg::DET_LOCKED);
   assign first_pll_lock = firstLockRaw & ~holdover;
   assign secondPllLock  = (secondState == ref_select_pkg::DET_LOCKED);

   // Status pin routing
   function automatic logic statusMux(input logic [1:0] sel, input logic l1, input logic l2,
                                      input logic h);
      case (sel)
         ref_select_pkg::STATUS_FIRST:  return l1;
         ref_select_pkg::STATUS_SECOND: return l2;
         ref_select_pkg::STATUS_BOTH:   return l1 & l2;
         default:                       return h;
      endcase
   endfunction

   always_comb begin
      status_pin_a = statusMux(statusSelectA, first_pll_lock, secondPllLock, holdover);
      status_pin_b = statusMux(statusSelectB, first_pll_lock, secondPllLock, holdover);
   end

   // Assertions
   sequence seqMiss1;
      firstCompare && !firstInWindow;
   endsequence

   AST_MANUAL_FIXED: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode < ref_select_pkg::MODE_PIN) |=> activeInput == $past(input_select_mode[1:0]))
      else $error("manual mode input mismatch");
   AST_MANUAL_RUN: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode < ref_select_pkg::MODE_PIN) |-> bufferRun[activeInput])
      else $error("manual buffer not running");
   AST_PIN_HOLD: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode == ref_select_pkg::MODE_PIN && pinCode == 2'h3) |=> holdover)
      else $error("pins 11 did not force holdover");
   AST_PIN_SEL: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode == ref_select_pkg::MODE_PIN && pinCode != 2'h3)
      |=> activeInput == $past(pinCode) && !holdover)
      else $error("pin select mismatch");
   AST_PIN_TYPE: assert property (@(posedge clk) disable iff (srst)
      !select_pin_type[0] |-> !pin0Level)
      else $error("output-typed pin not low");
   AST_AUTO_SKIP: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode == ref_select_pkg::MODE_AUTO && prevMode == ref_select_pkg::MODE_AUTO
       && switchEvent && $changed(next_activeInput)) |=> input_buffer_enable[activeInput])
      else $error("auto switched to disabled input");
   AST_LOCK_DROP: assert property (@(posedge clk) disable iff (srst)
      seqMiss1 |=> !firstLockRaw && firstCount == '0)
      else $error("lock not dropped on miss");
   AST_LOCK_REACH: assert property (@(posedge clk) disable iff (srst)
      (firstCompare && firstInWindow && !firstLockRaw
       && firstCount + 1'b1 == first_pll_lock_count_target) |=> firstLockRaw)
      else $error("lock not asserted at target");
   AST_HOLD_LOCK: assert property (@(posedge clk) disable iff (srst)
      holdover |-> !first_pll_lock)
      else $error("first lock shown in holdover");
   AST_BOTH: assert property (@(posedge clk) disable iff (srst)
      statusSelectA == ref_select_pkg::STATUS_BOTH |-> status_pin_a == (first_pll_lock & secondPllLock))
      else $error("combined lock wrong");

   // Step shapes shared by the detector properties below
   sequence seqCount1;
      firstCompare && firstInWindow && !firstLockRaw && firstCount != '1;
   endsequence

   sequence seqMiss2;
      secondCompare && !secondInWindow;
   endsequence

   sequence seqReach2;
      secondCompare && secondInWindow && !secondPllLock
      && secondCount + 1'b1 == second_pll_lock_count_target;
   endsequence

   // Pin path: both pins typed, one invert bit, chosen buffer kept on
   AST_PIN_RUN: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode == ref_select_pkg::MODE_PIN) |-> bufferRun[activeInput])
      else $error("pin-chosen buffer not running");
   AST_PIN_TYPE1: assert property (@(posedge clk) disable iff (srst)
      !select_pin_type[1] |-> !pin1Level)
      else $error("output-typed pin one not low");
   AST_PIN_INVERT: assert property (@(posedge clk) disable iff (srst)
      (select_pin_type == 2'h3)
      |-> pinCode == ({select_pin_1, select_pin_0} ^ {2{select_pin_invert}}))
      else $error("select pin inversion wrong");

   // Manual relock after holdover lands on the programmed input
   AST_HOLD_RELOCK: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode < ref_select_pkg::MODE_PIN && holdover && holdoverExit)
      |=> !holdover && activeInput == $past(input_select_mode[1:0]))
      else $error("manual relock went elsewhere");

   // Automatic mode: entry keeps a locked input, switches step in order
   AST_AUTO_ENTRY: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode == ref_select_pkg::MODE_AUTO && prevMode != ref_select_pkg::MODE_AUTO
       && first_pll_lock) |=> activeInput == $past(activeInput))
      else $error("auto entry left a locked input");
   AST_AUTO_ORDER: assert property (@(posedge clk) disable iff (srst)
      (input_select_mode == ref_select_pkg::MODE_AUTO && prevMode == ref_select_pkg::MODE_AUTO
       && switchEvent && input_buffer_enable == 3'h7)
      |=> activeInput == (($past(activeInput) == ref_select_pkg::INPUT_2) ?
                          ref_select_pkg::INPUT_0 : $past(activeInput) + 2'h1))
      else $error("auto order wrong");

   // Detectors: count steps, second PLL reaches and drops, lock holds between misses
   AST_COUNT_STEP: assert property (@(posedge clk) disable iff (srst)
      seqCount1 |=> firstCount == $past(firstCount) + 1'b1)
      else $error("in-window compare did not count");
   AST_LOCK_REACH2: assert property (@(posedge clk) disable iff (srst)
      seqReach2 |=> secondPllLock)
      else $error("second lock not asserted at target");
   AST_LOCK_DROP2: assert property (@(posedge clk) disable iff (srst)
      seqMiss2 |=> !secondPllLock && secondCount == '0)
      else $error("second miss did not clear");
   AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (srst)
      (firstLockRaw && !(firstCompare && !firstInWindow)) |=> firstLockRaw)
      else $error("lock fell without a miss");

   // Status routing for the remaining selections
   AST_STATUS_SECOND: assert property (@(posedge clk) disable iff (srst)
      statusSelectB == ref_select_pkg::STATUS_SECOND |-> status_pin_b == secondPllLock)
      else $error("status b second lock wrong");
   AST_STATUS_HOLD: assert property (@(posedge clk) disable iff (srst)
      statusSelectA == ref_select_pkg::STATUS_HOLD |-> status_pin_a == holdover)
      else $error("status a holdover wrong");
endmodule

// File: tb/ref_host_model.sv
// Host-side model: select pin drivers and phase comparison pulses for both PLLs
`timescale 1ns/1ps
module ref_host_model (
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [1:0] wantPins,
   input  wire logic [1:0] wantCmp,
   input  wire logic [1:0] wantWin,
   output logic            selPin0,
   output logic            selPin1,
   output logic [1:0]      cmpPulse,
   output logic [1:0]      inWin
);
   logic [1:0] next_pins;
   logic [1:0] next_win;

   // Window flag is only meaningful with a compare; otherwise it shows the inverse
   always_comb begin
      next_pins = wantPins;
      next_win  = wantWin ^ ~wantCmp;
   end

   // Registered so every request leaves just after a clock edge
   always_ff @(posedge clk) begin
      if (srst) begin
         {selPin1, selPin0} <= 2'h0;
         cmpPulse           <= 2'h0;
         inWin              <= 2'h0;
      end else begin
         {selPin1, selPin0} <= next_pins;
         cmpPulse           <= wantCmp;
         inWin              <= next_win;
      end
   end
endmodule

// File: tb/ref_clock_select_lock_detect_test.sv
// Self-checking bench for reference selection and lock detect
`timescale 1ns/1ps
module ref_clock_select_lock_detect_test;
   logic        clk, srst, pinInv, switchEvent, holdoverExit, selPin0, selPin1;
   logic        holdover, lock1, lock2, stA, stB;
   logic [2:0]  mode, bufEn, bufferRun;
   logic [1:0]  pinType, wantPins, wantCmp, wantWin, cmpPulse, inWin;
   logic [1:0]  statusSelA, statusSelB, activeInput, eff;
   logic [15:0] target1, target2;
   int          n_mismatch, n_tests, cycles;

   ref_clock_select_lock_detect #(.COUNT_WIDTH(16)) u_ref_clock_select_lock_detect (
      .clk(clk), .srst(srst), .input_select_mode(mode), .input_buffer_enable(bufEn),
      .select_pin_0(selPin0), .select_pin_1(selPin1), .select_pin_type(pinType),
      .select_pin_invert(pinInv), .switchEvent(switchEvent), .holdoverExit(holdoverExit),
      .firstCompare(cmpPulse[0]), .firstInWindow(inWin[0]), .secondCompare(cmpPulse[1]),
      .secondInWindow(inWin[1]), .first_pll_lock_count_target(target1),
      .second_pll_lock_count_target(target2), .statusSelectA(statusSelA),
      .statusSelectB(statusSelB), .activeInput(activeInput), .bufferRun(bufferRun),
      .holdover(holdover), .first_pll_lock(lock1), .secondPllLock(lock2),
      .status_pin_a(stA), .status_pin_b(stB));
   ref_host_model u_ref_host_model (
      .clk(clk), .srst(srst), .wantPins(wantPins), .wantCmp(wantCmp), .wantWin(wantWin),
      .selPin0(selPin0), .selPin1(selPin1), .cmpPulse(cmpPulse), .inWin(inWin));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         $display("[ERR] %0t run did not complete", $time);
         close_out();
      end
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Judges the value handed in; callers take it at the falling edge, once updates have landed
   task automatic chk_val(input logic [2:0] got, input logic [2:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One phase comparison; model adds a cycle, design answers one cycle later
   task automatic compare(input int pll, input logic win);
      tick(1);
      wantCmp[pll] <= 1'b1;
      wantWin[pll] <= win;
      tick(1);
      wantCmp[pll] <= 1'b0;
      tick(2);
   endtask

   task automatic pulse(input logic exitHold);
      tick(1);
      if (exitHold) holdoverExit <= 1'b1;
      else switchEvent <= 1'b1;
      tick(1);
      holdoverExit <= 1'b0;
      switchEvent <= 1'b0;
      tick(2);
   endtask

   task automatic t_manual();
      for (int m = 0; m < 3; m++) begin
         tick(1);
         mode  <= m[2:0];
         bufEn <= 3'h0;
         tick(3);
         @(negedge clk);
         chk_val({1'b0, activeInput}, m[2:0]);
         chk_val(bufferRun & (3'h1 << m), 3'h1 << m);
      end
   endtask

   task automatic t_pins();
      tick(1);
      mode    <= ref_select_pkg::MODE_PIN;
      pinType <= 2'h3;
      for (int k = 0; k < 8; k++) begin
         tick(1);
         wantPins <= k[1:0];
         pinInv   <= k[2];
         tick(4);
         @(negedge clk);
         eff = k[1:0] ^ {2{k[2]}};
         if (eff == ref_select_pkg::PINS_HOLD) chk_val({2'h0, holdover}, 3'h1);
         else begin
            chk_val({1'b0, activeInput}, {1'b0, eff});
            chk_val(bufferRun & (3'h1 << eff), 3'h1 << eff);
         end
      end
      // Pins typed as outputs read low whatever the wire shows
      tick(1);
      pinInv   <= 1'b0;
      pinType  <= 2'h1;
      wantPins <= 2'h3;
      tick(4);
      @(negedge clk);
      chk_val({1'b0, activeInput}, 3'h1);
      tick(1);
      pinType <= 2'h3;
      tick(4);
      @(negedge clk);
      chk_val({2'h0, holdover}, 3'h1);
   endtask

   task automatic t_hold();
      compare(0, 1'b1);
      compare(0, 1'b1);
      compare(0, 1'b1);
      statusSelA <= ref_select_pkg::STATUS_HOLD;
      @(negedge clk);
      chk_val({1'b0, lock1, stA}, 3'h1);
      tick(1);
      mode <= ref_select_pkg::MODE_MANUAL_1;
      pulse(1'b1);
      @(negedge clk);
      chk_val({holdover, activeInput}, 3'h1);
      chk_val({2'h0, lock1}, 3'h1);
   endtask

   task automatic t_lock();
      compare(0, 1'b0);
      @(negedge clk);
      chk_val({2'h0, lock1}, 3'h0);
      compare(0, 1'b1);
      compare(0, 1'b1);
      compare(0, 1'b0);
      compare(0, 1'b1);
      compare(0, 1'b1);
      @(negedge clk);
      chk_val({2'h0, lock1}, 3'h0);
      compare(0, 1'b1);
      @(negedge clk);
      chk_val({2'h0, lock1}, 3'h1);
      compare(1, 1'b1);
      @(negedge clk);
      chk_val({1'b0, lock2, lock1}, 3'h1);
      compare(1, 1'b1);
      @(negedge clk);
      chk_val({1'b0, lock2, lock1}, 3'h3);
      for (int s = 0; s < 3; s++) begin
         tick(1);
         statusSelA <= s[1:0];
         @(negedge clk);
         chk_val({2'h0, stA}, 3'h1);
      end
      compare(0, 1'b0);
      statusSelB <= ref_select_pkg::STATUS_SECOND;
      @(negedge clk);
      chk_val({1'b0, stA, stB}, 3'h1);
   endtask

   task automatic t_auto();
      tick(1);
      bufEn <= 3'h7;
      compare(0, 1'b1);
      compare(0, 1'b1);
      compare(0, 1'b1);
      mode <= ref_select_pkg::MODE_AUTO;
      tick(3);
      @(negedge clk);
      chk_val({1'b0, activeInput}, 3'h1);
      pulse(1'b0);
      @(negedge clk);
      chk_val({1'b0, activeInput}, 3'h2);
      pulse(1'b0);
      @(negedge clk);
      chk_val({1'b0, activeInput}, 3'h0);
      tick(1);
      bufEn <= 3'h5;
      pulse(1'b0);
      @(negedge clk);
      chk_val({1'b0, activeInput}, 3'h2);
   endtask

   initial begin
      {srst, pinInv, switchEvent, holdoverExit} = 4'h8;
      {mode, bufEn} = 6'h00;
      {pinType, wantPins, wantCmp, wantWin, statusSelA, statusSelB} = 12'h000;
      target1 = 16'h0003;
      target2 = 16'h0002;
      {n_mismatch, n_tests, cycles} = '0;
      tick(12);
      srst <= 1'b0;
      t_manual();
      t_pins();
      t_hold();
      t_lock();
      t_auto();
      close_out();
   end
endmodule
